// file: dv/pxr_link_sva.sv
// link protocol checks between host end and paged bank end
`timescale 1ns/1ns
module pxr_link_sva (
	input wire logic       CLK,   // clock
	input wire logic       SRST,  // sync reset
	input wire logic       CE,    // clock enable
	input wire logic       req,   // request
	input wire logic       we,    // write select
	input wire logic [7:0] addr,  // primary address
	input wire logic [7:0] wdata, // write byte
	input wire logic [7:0] rdata, // read byte
	input wire logic       ack    // answer pulse
);
	logic ce_q;

	// CE as seen at the last edge: that edge moved nothing when low
	always_ff @(posedge CLK) begin
		ce_q <= CE;
	end

	// frozen cycles on either side abort attempts rather than fake a failure
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST || !CE || !ce_q);

	// link steps, each closed by its answer
	sequence s_open;
		req && we && addr == 8'h01 && wdata == 8'h80 ##1 ack;
	endsequence
	sequence s_addr;
		req && we && addr == 8'h08 ##1 ack;
	endsequence
	sequence s_mclr;
		req && we && addr == 8'h17 && wdata == 8'h00 ##1 ack;
	endsequence
	property p_held;
		req && !ack |=> req && $stable({we, addr, wdata});
	endproperty
	property p_mode;
		s_open |-> ##2 req && we && addr == 8'h17
			&& (wdata == 8'h20 || wdata == 8'h40);
	endproperty
	property p_close;
		s_mclr |-> ##2 req && we && addr == 8'h01 && wdata == 8'h00;
	endproperty

	chk_ack_after_take: assert property (req && !ack |=> ack)
		else $error("no answer after request");
	chk_ack_one_cycle: assert property (ack |=> !ack)
		else $error("answer longer than one cycle");
	chk_ack_has_cause: assert property ($rose(ack) |-> $past(req))
		else $error("answer without request");
	chk_req_released: assert property (ack |=> !req)
		else $error("request kept after answer");
	chk_req_held: assert property (p_held)
		else $error("request changed before answer");
	chk_rdata_hold: assert property (!(req && !ack) |=> $stable(rdata))
		else $error("read byte moved without request");
	chk_open_order: assert property (p_mode)
		else $error("mode step not after enable");
	chk_addr_data: assert property (s_addr |-> ##2 req && addr == 8'h09)
		else $error("data step not after address");
	chk_close_order: assert property (p_close)
		else $error("disable step not after mode clear");
endmodule

// file: dv/pxr_tb_top.sv
// self-checking bench: host end and bank end joined on one link
`timescale 1ns/1ns
module pxr_tb_top;
	typedef struct packed {
		logic [3:0]      pg;
		logic [7:0]      a;
		logic [7:0]      n;
		logic [9:0][7:0] exp;
	} pxr_row_s;

	logic               CLK;
	logic               SRST = 1'b1;
	logic               CE = 1'b1;
	logic               START = 1'b0;
	logic               WRITE = 1'b0;
	logic [3:0]         PAGE = 4'h0;
	logic [7:0]         ADDR = 8'h00;
	logic [7:0]         COUNT = 8'h00;
	logic [7:0]         WDATA = 8'h00;
	logic               WDATA_VALID = 1'b0;
	logic               WDATA_READY, RDATA_VALID, BUSY, DONE;
	logic [7:0]         RDATA;
	pxr_pkg::pxr_half_s gbx, gby, gbz, gain, offx, offy, offz;
	pxr_pkg::pxr_half_s c11, c12, c21;
	logic               comp, sp_open;
	logic [3:0]         pnow;
	int                 bad_count = 0;
	int                 num_checks = 0;
	int                 cycles = 0;
	logic [9:0][7:0]    rd;
	pxr_row_s           rows [5];

	pxr_bus_if u_pxr_bus_if ();
	pxr_dev u_pxr_dev (.CLK(CLK), .SRST(SRST), .CE(CE),
		.BUS(u_pxr_bus_if.dev), .GYRO_BIAS_X(gbx), .GYRO_BIAS_Y(gby),
		.GYRO_BIAS_Z(gbz), .EXT_GAIN(gain), .EXT_OFF_X(offx),
		.EXT_OFF_Y(offy), .EXT_OFF_Z(offz), .EXT_COEF_11(c11),
		.EXT_COEF_12(c12), .EXT_COEF_21(c21), .EXT_COMP_ACTIVE(comp),
		.SPACE_OPEN(sp_open), .PAGE_NOW(pnow));
	pxr_host u_pxr_host (.CLK(CLK), .SRST(SRST), .CE(CE),
		.BUS(u_pxr_bus_if.host), .START(START), .WRITE(WRITE),
		.PAGE(PAGE), .ADDR(ADDR), .COUNT(COUNT), .WDATA(WDATA),
		.WDATA_VALID(WDATA_VALID), .WDATA_READY(WDATA_READY),
		.RDATA(RDATA), .RDATA_VALID(RDATA_VALID), .BUSY(BUSY),
		.DONE(DONE));
	pxr_link_sva u_pxr_link_sva (.CLK(CLK), .SRST(SRST), .CE(CE),
		.req(u_pxr_bus_if.req), .we(u_pxr_bus_if.we),
		.addr(u_pxr_bus_if.addr), .wdata(u_pxr_bus_if.wdata),
		.rdata(u_pxr_bus_if.rdata), .ack(u_pxr_bus_if.ack));

	// 20 MHz clock
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end

	// hang guard, far above the few hundred cycles the whole run needs
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input string nm, input logic [79:0] seen,
			input logic [79:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
		end
	endtask

	// one host burst; write bytes stall a cycle after every odd byte
	task automatic burst(input logic wr, input logic [3:0] pg,
			input logic [7:0] a, input logic [7:0] n,
			input logic [9:0][7:0] wd);
		int k;
		int r;
		int w;
		logic opened;
		logic [3:0] pn;
		k = 0;
		r = 0;
		w = 0;
		opened = 1'b0;
		pn = 4'h0;
		rd = '0;
		// the previous burst's last drive keeps its own time step
		@(posedge CLK);
		check("busy idle", BUSY, 1'b0);
		START <= 1'b1;
		WRITE <= wr;
		PAGE <= pg;
		ADDR <= a;
		COUNT <= n;
		WDATA <= wd[0];
		WDATA_VALID <= wr;
		@(posedge CLK);
		START <= 1'b0;
		do begin
			@(posedge CLK);
			w++;
			if (sp_open === 1'b1) begin
				opened = 1'b1;
				pn = pnow;
			end
			if (RDATA_VALID === 1'b1 && r < 10) begin
				rd[r] = RDATA;
				r++;
			end
			if (WDATA_READY === 1'b1 && WDATA_VALID === 1'b1) begin
				k++;
				WDATA <= wd[k % 10];
				WDATA_VALID <= wr && k < n && k % 2 == 0;
			end else
				WDATA_VALID <= wr && k < n;
		end while (DONE !== 1'b1 && w < 300);
		check("done", DONE, 1'b1);
		check("busy at done", BUSY, 1'b0);
		check("space opened", opened, 1'b1);
		check("space closed", sp_open, 1'b0);
		check("page seen", pn, pg);
	endtask

	initial begin
		rows[0] = '{4'h0, 8'h6e, 8'h06, 80'h0};
		rows[1] = '{4'h0, 8'hba, 8'h02, 80'h1624};
		rows[2] = '{4'h0, 8'hc0, 8'h0a, 80'h3c00_0000_0000_0000};
		rows[3] = '{4'h1, 8'h6e, 8'h02, 80'h0};
		rows[4] = '{4'h0, 8'hfe, 8'h04, 80'h0};
		repeat (8) @(posedge CLK);
		SRST <= 1'b0;
		@(posedge CLK);
		check("gain rst", gain, 16'h1624);
		check("c11 rst", c11, 16'h3c00);
		check("comp rst", comp, 1'b0);
		check("bias rst", {gbx, gby, gbz}, 48'h0);
		check("off rst", {offx, offy, offz, c12}, 64'h0);
		foreach (rows[i]) begin
			burst(1'b0, rows[i].pg, rows[i].a, rows[i].n, '0);
			check("row read", rd, rows[i].exp);
		end
		// full compensation block written, then read with a freeze
		burst(1'b1, 4'h0, 8'hc0, 8'h0a, 80'hc9c8_c7c6_c5c4_c3c2_c1c0);
		check("off xyz", {offx, offy, offz}, 48'hc1c0_c3c2_c5c4);
		check("c11", c11, 16'hc7c6);
		check("c12 c21", {c12, c21}, 32'hc9c8_c9c8);
		check("comp on", comp, 1'b1);
		fork
			burst(1'b0, 4'h0, 8'hc0, 8'h0a, '0);
			begin
				repeat (6) @(posedge CLK);
				CE <= 1'b0;
				repeat (5) @(posedge CLK);
				CE <= 1'b1;
			end
		join
		check("readback", rd, 80'hc9c8_c7c6_c5c4_c3c2_c1c0);
		burst(1'b1, 4'h0, 8'h6e, 8'h06, 80'hbc00_3c00_c2a5);
		check("bias sign", gbx.sign, 1'b1);
		check("bias expo", gbx.expo, 5'h10);
		check("bias frac", gbx.frac, 10'h2a5);
		check("bias yz", {gby, gbz}, 32'h3c00_bc00);
		burst(1'b1, 4'h1, 8'h6e, 8'h02, 80'hffff);
		check("page1 apart", gbx, 16'hc2a5);
		burst(1'b1, 4'h0, 8'hc0, 8'h0a, 80'h3c00_0000_0000_0000);
		check("comp off", comp, 1'b0);
		// reset in mid-run restores every stored value
		SRST <= 1'b1;
		repeat (2) @(posedge CLK);
		SRST <= 1'b0;
		@(posedge CLK);
		check("bias rst2", gbx, 16'h0);
		check("busy rst2", BUSY, 1'b0);
		conclude();
	end
endmodule

// file: rtl/pxr_bus_if.sv
// byte register link between host processor and paged bank
`timescale 1ns/1ns
interface pxr_bus_if;
	logic       req;
	logic       we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       ack;
	modport host (output req, we, addr, wdata, input rdata, ack);
	modport dev  (input req, we, addr, wdata, output rdata, ack);
endinterface

// file: rtl/pxr_dev.sv
// device end: primary paging registers and the page 0 bank behind them
`timescale 1ns/1ns
`include "pxr_map.svh"
module pxr_dev #(
	parameter int NREG = `PXR_P0_NREG
) (
	input  wire logic         CLK,            // 20 MHz system clock
	input  wire logic         SRST,           // synchronous reset
	input  wire logic         CE,             // clock enable
	pxr_bus_if.dev            BUS,            // host register link
	output pxr_pkg::pxr_half_s GYRO_BIAS_X,   // fusion gyro bias x
	output pxr_pkg::pxr_half_s GYRO_BIAS_Y,   // fusion gyro bias y
	output pxr_pkg::pxr_half_s GYRO_BIAS_Z,   // fusion gyro bias z
	output pxr_pkg::pxr_half_s EXT_GAIN,      // external sensor gain
	output pxr_pkg::pxr_half_s EXT_OFF_X,     // external offset x
	output pxr_pkg::pxr_half_s EXT_OFF_Y,     // external offset y
	output pxr_pkg::pxr_half_s EXT_OFF_Z,     // external offset z
	output pxr_pkg::pxr_half_s EXT_COEF_11,   // rotation row1 col1
	output pxr_pkg::pxr_half_s EXT_COEF_12,   // rotation row1 col2
	output pxr_pkg::pxr_half_s EXT_COEF_21,   // rotation row2 col1
	output logic              EXT_COMP_ACTIVE,// state engine input altered
	output logic              SPACE_OPEN,     // embedded space reachable
	output logic [3:0]        PAGE_NOW        // page currently selected
);
	// two bytes make one half-float value
	localparam int PAIR = 2;

	pxr_pkg::pxr_dev_s    s_reg;
	pxr_pkg::pxr_dev_s    s_next;
	logic                 take;
	logic                 bank_we;
	logic [7:0]           bank_rdata;
	logic                 bank_hit;
	logic                 on_page0;
	logic                 data_acc;
	logic [NREG-1:0][7:0] regs;
	logic                 off_zero;
	logic                 mat_unity;
	logic                 bank_rd;
	pxr_pkg::pxr_half_s   half_v [NREG / PAIR];

	if (NREG != `PXR_P0_NREG) begin : g_chk
		$error("pxr_dev: NREG must match the page 0 map");
	end

	// the bank answers only for page 0; other pages read as zero
	assign on_page0 = (s_reg.page == `PXR_PAGE0);

	// storage follows the paging pointer; writes land at the taking edge
	pxr_page0_bank #(
		.NREG (NREG)
	) u_bank (
		.clk   (CLK),
		.srst  (SRST),
		.ce    (CE),
		.wr_en (bank_we),
		.addr  (s_reg.paddr),
		.wdata (BUS.wdata),
		.rdata (bank_rdata),
		.hit   (bank_hit),
		.regs  (regs)
	);

	// a request is taken when raised and not already answered
	assign take = BUS.req && !s_reg.ack;

	// a data access counts only while the space is open and the mode matching its direction is set
	always_comb begin
		data_acc = 1'b0;
		if (take && s_reg.en && (BUS.addr == `PXR_A_PAGE_DATA)) begin
			data_acc = BUS.we ? s_reg.wr_mode : s_reg.rd_mode;
		end
	end

	// write reaches storage only in write mode and on page 0
	assign bank_we = data_acc && BUS.we && on_page0;

	// read byte comes from storage only for a mapped page 0 entry
	assign bank_rd = data_acc && !BUS.we && on_page0 && bank_hit;

	// register decode and paging state
	always_comb begin
		s_next     = s_reg;
		s_next.ack = 1'b0;
		if (take) begin
			s_next.ack   = 1'b1;
			s_next.rdata = `PXR_R_ZERO;
			case (BUS.addr)
				`PXR_A_FUNC_ACCESS: begin
					// only the enable bit is kept; the rest read zero
					if (BUS.we) begin
						s_next.en = BUS.wdata[`PXR_B_SPACE_EN];
					end else begin
						s_next.rdata[`PXR_B_SPACE_EN] = s_reg.en;
					end
				end
				`PXR_A_PAGE_SELECT: begin
					// bits above the page field are dropped
					if (s_reg.en) begin
						if (BUS.we) begin
							s_next.page =
								BUS.wdata[`PXR_F_PAGE_HI:`PXR_F_PAGE_LO];
						end else begin
							s_next.rdata[`PXR_F_PAGE_HI:`PXR_F_PAGE_LO] =
								s_reg.page;
						end
					end
				end
				`PXR_A_PAGE_ADDR: begin
					if (s_reg.en) begin
						if (BUS.we) begin
							s_next.paddr = BUS.wdata;
						end else begin
							s_next.rdata = s_reg.paddr;
						end
					end
				end
				`PXR_A_PAGE_RW: begin
					if (s_reg.en) begin
						if (BUS.we) begin
							s_next.rd_mode = BUS.wdata[`PXR_B_PAGE_READ];
							s_next.wr_mode = BUS.wdata[`PXR_B_PAGE_WRITE];
						end else begin
							s_next.rdata[`PXR_B_PAGE_READ]  = s_reg.rd_mode;
							s_next.rdata[`PXR_B_PAGE_WRITE] = s_reg.wr_mode;
						end
					end
				end
				`PXR_A_PAGE_DATA: begin
					// pages without storage read zero and drop writes
					if (bank_rd) begin
						s_next.rdata = bank_rdata;
					end
				end
				default: begin
					// unmapped primary address: reads zero, writes ignored
				end
			endcase
			// step on so a run of consecutive registers needs data only
			// an access refused for a wrong mode leaves the pointer still
			if (data_acc) begin
				s_next.paddr = s_reg.paddr + 8'h01;
			end
		end
	end

	// single state register; clock enable freezes everything
	always_ff @(posedge CLK) begin
		if (SRST) begin
			s_reg <= '0;
		end else if (CE) begin
			s_reg <= s_next;
		end
	end

	// answer and read byte come straight from flops
	assign BUS.ack   = s_reg.ack;
	assign BUS.rdata = s_reg.rdata;

	// little-endian byte pairs viewed as half floats, one per value
	for (genvar v = 0; v < NREG / PAIR; v++) begin : g_half
		assign half_v[v] = {regs[PAIR * v + 1], regs[PAIR * v]};
	end

	// each output picks its value by the index of its low byte
	assign GYRO_BIAS_X = half_v[`PXR_I_GBX / PAIR];
	assign GYRO_BIAS_Y = half_v[`PXR_I_GBY / PAIR];
	assign GYRO_BIAS_Z = half_v[`PXR_I_GBZ / PAIR];
	assign EXT_GAIN    = half_v[`PXR_I_GAIN / PAIR];
	assign EXT_OFF_X   = half_v[`PXR_I_OFFX / PAIR];
	assign EXT_OFF_Y   = half_v[`PXR_I_OFFY / PAIR];
	assign EXT_OFF_Z   = half_v[`PXR_I_OFFZ / PAIR];
	assign EXT_COEF_11 = half_v[`PXR_I_C11 / PAIR];

	// symmetric matrix: one stored coefficient feeds both positions
	assign EXT_COEF_12 = half_v[`PXR_I_C12 / PAIR];
	assign EXT_COEF_21 = EXT_COEF_12;

	// offsets zero and unity diagonal with zero cross term: no correction
	assign off_zero  = (EXT_OFF_X == '0) && (EXT_OFF_Y == '0)
		&& (EXT_OFF_Z == '0);
	assign mat_unity = (regs[`PXR_I_C11] == `PXR_R_ZERO)
		&& (regs[`PXR_I_C11 + 1] == `PXR_R_C11_H)
		&& (EXT_COEF_12 == '0);
	// only the state engine path sees this; fusion data is untouched
	assign EXT_COMP_ACTIVE = !(off_zero && mat_unity);

	// status views of the paging registers
	assign SPACE_OPEN = s_reg.en;
	assign PAGE_NOW   = s_reg.page;
endmodule

// file: rtl/pxr_host.sv
// host end: runs the enable, mode, page, address, data, close sequence
`timescale 1ns/1ns
`include "pxr_map.svh"
module pxr_host (
	input  wire logic       CLK,         // 20 MHz system clock
	input  wire logic       SRST,        // synchronous reset
	input  wire logic       CE,          // clock enable
	pxr_bus_if.host         BUS,         // device register link
	input  wire logic       START,       // begin a burst, level sampled
	input  wire logic       WRITE,       // 1 write burst, 0 read burst
	input  wire logic [3:0] PAGE,        // target page
	input  wire logic [7:0] ADDR,        // first paged address
	input  wire logic [7:0] COUNT,       // bytes in burst, 0 means 1
	input  wire logic [7:0] WDATA,       // next byte to write
	input  wire logic       WDATA_VALID, // WDATA holds a byte
	output logic            WDATA_READY, // byte taken this cycle
	output logic [7:0]      RDATA,       // last byte read
	output logic            RDATA_VALID, // pulse with each read byte
	output logic            BUSY,        // sequence in progress
	output logic            DONE         // pulse when access closed
);
	pxr_pkg::pxr_host_s s_reg;
	pxr_pkg::pxr_host_s s_next;
	logic               idle_bus;

	assign idle_bus    = !s_reg.req;
	assign WDATA_READY = (s_reg.st == pxr_pkg::H_DATA) && s_reg.wr
		&& idle_bus;

	// each state after idle issues one link request and moves on at its answer; data issues one per byte
	always_comb begin
		s_next        = s_reg;
		s_next.rvalid = 1'b0;
		s_next.done   = 1'b0;
		if (s_reg.req && BUS.ack) begin
			s_next.req = 1'b0;
		end
		unique case (s_reg.st)
			pxr_pkg::H_IDLE: begin
				if (START) begin
					s_next.st   = pxr_pkg::H_ENABLE;
					s_next.wr   = WRITE;
					s_next.page = PAGE;
					s_next.base = ADDR;
					s_next.cnt  = (COUNT == 8'h00) ? 8'h01 : COUNT;
				end
			end
			pxr_pkg::H_ENABLE: begin
				if (idle_bus) begin
					s_next.req   = 1'b1;
					s_next.we    = 1'b1;
					s_next.addr  = `PXR_A_FUNC_ACCESS;
					s_next.wdata = 8'h00;
					s_next.wdata[`PXR_B_SPACE_EN] = 1'b1;
				end else if (BUS.ack) begin
					s_next.st = pxr_pkg::H_MODE;
				end
			end
			pxr_pkg::H_MODE: begin
				if (idle_bus) begin
					s_next.req   = 1'b1;
					s_next.addr  = `PXR_A_PAGE_RW;
					s_next.wdata = 8'h00;
					s_next.wdata[`PXR_B_PAGE_READ]  = !s_reg.wr;
					s_next.wdata[`PXR_B_PAGE_WRITE] = s_reg.wr;
				end else if (BUS.ack) begin
					s_next.st = pxr_pkg::H_PAGE;
				end
			end
			pxr_pkg::H_PAGE: begin
				if (idle_bus) begin
					s_next.req   = 1'b1;
					s_next.addr  = `PXR_A_PAGE_SELECT;
					s_next.wdata = 8'h00;
					s_next.wdata[`PXR_F_PAGE_HI:`PXR_F_PAGE_LO] = s_reg.page;
				end else if (BUS.ack) begin
					s_next.st = pxr_pkg::H_ADDR;
				end
			end
			pxr_pkg::H_ADDR: begin
				if (idle_bus) begin
					s_next.req   = 1'b1;
					s_next.addr  = `PXR_A_PAGE_ADDR;
					s_next.wdata = s_reg.base;
				end else if (BUS.ack) begin
					s_next.st = pxr_pkg::H_DATA;
				end
			end
			pxr_pkg::H_DATA: begin
				// consecutive bytes reuse the device's own address step
				if (idle_bus && (!s_reg.wr || WDATA_VALID)) begin
					s_next.req   = 1'b1;
					s_next.we    = s_reg.wr;
					s_next.addr  = `PXR_A_PAGE_DATA;
					s_next.wdata = WDATA;
				end else if (s_reg.req && BUS.ack) begin
					s_next.rdata  = s_reg.wr ? s_reg.rdata : BUS.rdata;
					s_next.rvalid = !s_reg.wr;
					s_next.cnt    = s_reg.cnt - 8'h01;
					if (s_reg.cnt == 8'h01) begin
						s_next.st = pxr_pkg::H_MCLR;
					end
				end
			end
			pxr_pkg::H_MCLR: begin
				if (idle_bus) begin
					s_next.req   = 1'b1;
					s_next.we    = 1'b1;
					s_next.addr  = `PXR_A_PAGE_RW;
					s_next.wdata = 8'h00;
				end else if (BUS.ack) begin
					s_next.st = pxr_pkg::H_DISABLE;
				end
			end
			pxr_pkg::H_DISABLE: begin
				if (idle_bus) begin
					s_next.req   = 1'b1;
					s_next.addr  = `PXR_A_FUNC_ACCESS;
					s_next.wdata = 8'h00;
				end else if (BUS.ack) begin
					s_next.st   = pxr_pkg::H_IDLE;
					s_next.done = 1'b1;
				end
			end
			default: begin
				s_next.st = pxr_pkg::H_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			s_reg <= '0;
		end else if (CE) begin
			s_reg <= s_next;
		end
	end

	assign BUS.req     = s_reg.req;
	assign BUS.we      = s_reg.we;
	assign BUS.addr    = s_reg.addr;
	assign BUS.wdata   = s_reg.wdata;
	assign RDATA       = s_reg.rdata;
	assign RDATA_VALID = s_reg.rvalid;
	assign BUSY        = (s_reg.st != pxr_pkg::H_IDLE);
	assign DONE        = s_reg.done;
endmodule

// file: rtl/pxr_map.svh
// register offsets, field positions and reset values of the paged bank
`ifndef PXR_MAP_SVH
`define PXR_MAP_SVH
// primary registers seen on the host link
`define PXR_A_FUNC_ACCESS 8'h01
`define PXR_A_PAGE_SELECT 8'h02
`define PXR_A_PAGE_ADDR   8'h08
`define PXR_A_PAGE_DATA   8'h09
`define PXR_A_PAGE_RW     8'h17
`define PXR_B_SPACE_EN    7
`define PXR_B_PAGE_WRITE  6
`define PXR_B_PAGE_READ   5
`define PXR_F_PAGE_HI     3
`define PXR_F_PAGE_LO     0
`define PXR_PAGE0         4'h0
`define PXR_PAGE1         4'h1
// page 0 bank, one byte per entry
`define PXR_P0_NREG       18
`define PXR_A_GBX_L       8'h6e
`define PXR_A_GBX_H       8'h6f
`define PXR_A_GBY_L       8'h70
`define PXR_A_GBY_H       8'h71
`define PXR_A_GBZ_L       8'h72
`define PXR_A_GBZ_H       8'h73
`define PXR_A_GAIN_L      8'hba
`define PXR_A_GAIN_H      8'hbb
`define PXR_A_OFFX_L      8'hc0
`define PXR_A_OFFX_H      8'hc1
`define PXR_A_OFFY_L      8'hc2
`define PXR_A_OFFY_H      8'hc3
`define PXR_A_OFFZ_L      8'hc4
`define PXR_A_OFFZ_H      8'hc5
`define PXR_A_C11_L       8'hc6
`define PXR_A_C11_H       8'hc7
`define PXR_A_C12_L       8'hc8
`define PXR_A_C12_H       8'hc9
`define PXR_R_ZERO        8'h00
`define PXR_R_GAIN_L      8'h24
`define PXR_R_GAIN_H      8'h16
`define PXR_R_C11_H       8'h3c
// bank entry index of each 16-bit value (low byte)
`define PXR_I_GBX         0
`define PXR_I_GBY         2
`define PXR_I_GBZ         4
`define PXR_I_GAIN        6
`define PXR_I_OFFX        8
`define PXR_I_OFFY        10
`define PXR_I_OFFZ        12
`define PXR_I_C11         14
`define PXR_I_C12         16
`endif

// file: rtl/pxr_page0_bank.sv
// page 0 storage: fusion gyro bias and external sensor compensation
`timescale 1ns/1ns
`include "pxr_map.svh"
module pxr_page0_bank #(
	parameter int NREG = `PXR_P0_NREG
) (
	input  wire logic       clk,      // system clock
	input  wire logic       srst,     // synchronous reset
	input  wire logic       ce,       // clock enable
	input  wire logic       wr_en,    // write strobe
	input  wire logic [7:0] addr,     // paged address
	input  wire logic [7:0] wdata,    // write byte
	output logic      [7:0] rdata,    // read byte, zero if unmapped
	output logic            hit,      // address names an entry
	output logic [NREG-1:0][7:0] regs // all stored bytes
);
	localparam logic [7:0] ENT_ADDR [NREG] = '{
		`PXR_A_GBX_L, `PXR_A_GBX_H, `PXR_A_GBY_L, `PXR_A_GBY_H,
		`PXR_A_GBZ_L, `PXR_A_GBZ_H, `PXR_A_GAIN_L, `PXR_A_GAIN_H,
		`PXR_A_OFFX_L, `PXR_A_OFFX_H, `PXR_A_OFFY_L, `PXR_A_OFFY_H,
		`PXR_A_OFFZ_L, `PXR_A_OFFZ_H, `PXR_A_C11_L, `PXR_A_C11_H,
		`PXR_A_C12_L, `PXR_A_C12_H};
	localparam logic [7:0] ENT_RST [NREG] = '{
		`PXR_R_ZERO, `PXR_R_ZERO, `PXR_R_ZERO, `PXR_R_ZERO,
		`PXR_R_ZERO, `PXR_R_ZERO, `PXR_R_GAIN_L, `PXR_R_GAIN_H,
		`PXR_R_ZERO, `PXR_R_ZERO, `PXR_R_ZERO, `PXR_R_ZERO,
		`PXR_R_ZERO, `PXR_R_ZERO, `PXR_R_ZERO, `PXR_R_C11_H,
		`PXR_R_ZERO, `PXR_R_ZERO};

	pxr_pkg::pxr_bank_s s_reg;
	pxr_pkg::pxr_bank_s s_next;
	pxr_pkg::pxr_bank_s s_rst;
	logic [NREG-1:0]     hit_v;
	logic [NREG-1:0][7:0] rd_v;

	if (NREG != `PXR_P0_NREG) begin : g_chk
		$error("pxr_page0_bank: NREG must match the page 0 map");
	end

	// per-entry decode, reset image and read gating
	for (genvar i = 0; i < NREG; i++) begin : g_ent
		assign hit_v[i]     = (addr == ENT_ADDR[i]);
		assign s_rst.mem[i] = ENT_RST[i];
		assign rd_v[i]      = hit_v[i] ? s_reg.mem[i] : `PXR_R_ZERO;
	end

	assign hit  = |hit_v;
	assign regs = s_reg.mem;

	// read mux: only one entry can match, so an OR tree is enough
	always_comb begin
		rdata = `PXR_R_ZERO;
		for (int j = 0; j < NREG; j++) begin
			rdata = rdata | rd_v[j];
		end
	end

	// writes to unmapped addresses fall through and are dropped
	always_comb begin
		s_next = s_reg;
		for (int j = 0; j < NREG; j++) begin
			if (wr_en && hit_v[j]) begin
				s_next.mem[j] = wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_reg <= s_rst;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end
endmodule

// file: rtl/pxr_pkg.sv
// shared types of the paged register bank and its host
package pxr_pkg;
	// 16-bit half-precision value: sign, exponent, fraction
	typedef struct packed {
		logic       sign;
		logic [4:0] expo;
		logic [9:0] frac;
	} pxr_half_s;

	typedef struct packed {
		logic       en;
		logic       rd_mode;
		logic       wr_mode;
		logic [3:0] page;
		logic [7:0] paddr;
		logic [7:0] rdata;
		logic       ack;
	} pxr_dev_s;

	typedef struct packed {
		logic [17:0][7:0] mem;
	} pxr_bank_s;

	typedef enum logic [3:0] {
		H_IDLE, H_ENABLE, H_MODE, H_PAGE, H_ADDR, H_DATA, H_MCLR, H_DISABLE
	} pxr_hstate_e;

	typedef struct packed {
		pxr_hstate_e st;
		logic        req;
		logic        we;
		logic [7:0]  addr;
		logic [7:0]  wdata;
		logic        wr;
		logic [3:0]  page;
		logic [7:0]  base;
		logic [7:0]  cnt;
		logic [7:0]  rdata;
		logic        rvalid;
		logic        done;
	} pxr_host_s;
endpackage
